// *** shared/tsf_pkg.sv ***
package tsf_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] OFS_SYNC = 12'h000;
  localparam logic [11:0] OFS_AUX = 12'h004;
  localparam logic [11:0] OFS_FEAT = 12'h008;

  // ==========================================================
  // Sync period control fields
  localparam int CNT_W = 12;
  localparam int SYNC_MODE_BIT = 12;
  localparam int POW_LSB = 7;
  localparam int POW_MSB = 11;
  localparam logic SYNC_MODE_RST = 1'h0;
  localparam logic [12:0] PROBE_PATTERN = 13'h1FFF;

  // ==========================================================
  // Auxiliary control
  localparam logic [31:0] AUX_RST = 32'h0000_0000;

  // ==========================================================
  // Feature report one fields
  localparam int FEAT_SOFTWARE_OUTPUT_ENABLE_LSB = 22;
  localparam int FEAT_SYNC_ENABLE_LSB = 20;
  localparam int FEAT_SYNC_LSB = 8;
  localparam logic [1:0] SUP_PROBE = 2'h0;
  localparam logic [1:0] SUP_ABSENT = 2'h1;
  localparam logic [1:0] SUP_PRESENT = 2'h2;
  localparam logic [1:0] SUP_WRITABLE = 2'h3;
  localparam logic [1:0] SYNC_NO_MODE = 2'h2;
  localparam logic [1:0] SYNC_WITH_MODE = 2'h3;

  // ==========================================================
  // Register select, one-hot
  typedef enum logic [3:0]
  {
    REG_NONE = 4'h1,
    REG_SYNC = 4'h2,
    REG_AUX = 4'h4,
    REG_FEAT = 4'h8
  } tsf_reg_e;

endpackage

// *** shared/tsf_sync_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface tsf_sync_if;
  logic load;
  logic mode;
  logic [tsf_pkg::CNT_W-1:0] count;
  logic active;
  logic byte_stb;
  logic sync_en;
  logic sync_req;

  // ==========================================================
  // Register side and counter side
  modport regs (output load, mode, count, active, byte_stb, sync_en, input sync_req);
  modport cnt (input load, mode, count, active, byte_stb, sync_en, output sync_req);
endinterface
`default_nettype wire

// *** core/tsf_sync_counter.sv ***
`timescale 1ns/1ns
`default_nettype none
module tsf_sync_counter
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register side
  tsf_sync_if.cnt s
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_inc;
  logic [31:0] period;
  logic hit;
  logic sync_req_q;

  // ==========================================================
  // Period from mode and count
  always_comb
  begin
    if (s.mode)
    begin
      period = 32'h0000_0001 << s.count[tsf_pkg::POW_MSB:tsf_pkg::POW_LSB];
    end
    else
    begin
      period = {20'h00000, s.count};
    end
  end

  assign cnt_inc = cnt_q + 32'h0000_0001;
  // At or past the period, so a shortened period never overruns
  assign hit = s.active && s.byte_stb && !s.load && (cnt_inc >= period);

  // ==========================================================
  // Byte counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (s.load)
      begin
        cnt_q <= 32'h0000_0000;
      end
      else if (s.active && s.byte_stb)
      begin
        cnt_q <= hit ? 32'h0000_0000 : cnt_inc;
      end
    end
  end

  // ==========================================================
  // Sync request pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_req_q <= 1'h0;
    end
    else if (ce)
    begin
      sync_req_q <= s.sync_en && (s.load || hit);
    end
  end

  assign s.sync_req = sync_req_q;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_stop_when_zero;
    ce && !s.active && !s.load |=> !sync_req_q && cnt_q == $past(cnt_q);
  endproperty
  a_stop_when_zero: assert property (p_stop_when_zero)
    else $error("sync produced while counter stopped");

  property p_load_sync;
    ce && s.load |=> cnt_q == 32'h0000_0000 && sync_req_q == $past(s.sync_en);
  endproperty
  a_load_sync: assert property (p_load_sync)
    else $error("write did not restart count and sync");

  property p_period_hit;
    ce && s.active && s.byte_stb && !s.load && cnt_inc == period
      |=> cnt_q == 32'h0000_0000 && sync_req_q == $past(s.sync_en);
  endproperty
  a_period_hit: assert property (p_period_hit)
    else $error("period reached without sync");

  c_periodic_sync: cover property (ce && hit && s.sync_en);

endmodule
`default_nettype wire

// *** core/tsf_regs.sv ***
// Overview of operation
// - Mode bit 12 of sync control clear gives a period of N bytes from count bits 11:0.
// - Mode bit set gives a period of two to the N bytes, N from bits 11:7 used as written, 0..31.
// - The count field in bits 11:0 reads back what is held; its reset value is a parameter.
// - With the sync field at 00 an all-ones probe reads zero if absent, nonzero if present.
// - Count bits that are not built read as zero after the probe write.
// - Auxiliary control is 32 bits of local controls that reset to zero.
// - Feature report one is always present, read-only, with bits 31:24 reading zero.
// - Feature bits 23:22 report the software output enable: 00 probe, 01 absent, 10 present.
// - Feature bits 21:20 report sync enable: 00 probe, 01 absent, 10 reads one, 11 writable.
// - Writing zero to sync control stops the byte-based sync counter.
// - Any write to sync control syncs at once if enabled and restarts the byte count.
// - Feature bits 9:8 report sync control: 01 absent, 10 without mode, 11 with mode.
`timescale 1ns/1ns
`default_nettype none
module tsf_regs
#(
  parameter logic [11:0] COUNT_MASK = 12'hFFF,
  parameter logic [11:0] COUNT_RESET = 12'h000,
  parameter bit SYNC_PRESENT = 1'b1,
  parameter bit MODE_PRESENT = 1'b1,
  parameter logic [1:0] SOFTWARE_OUTPUT_ENABLE_SUPPORT = 2'h2,
  parameter logic [1:0] SYNC_ENABLE_SUPPORT = 2'h2
)
(
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tsf_pkg::ADDR_W-1:0] PADDR,
  input wire logic [tsf_pkg::DATA_W-1:0] PWDATA,
  output logic [tsf_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Trace stream side
  input wire logic TRACE_BYTE_STB,
  input wire logic SYNC_EN,
  output logic SYNC_REQ,
  // Local controls
  output logic [tsf_pkg::DATA_W-1:0] AUX_CTRL
);

  // ==========================================================
  // Address decode
  function automatic tsf_pkg::tsf_reg_e reg_decode(input logic [tsf_pkg::ADDR_W-1:0] a);
    tsf_pkg::tsf_reg_e r;
    r = tsf_pkg::REG_NONE;
    unique case (a)
      tsf_pkg::OFS_SYNC: r = tsf_pkg::REG_SYNC;
      tsf_pkg::OFS_AUX: r = tsf_pkg::REG_AUX;
      tsf_pkg::OFS_FEAT: r = tsf_pkg::REG_FEAT;
      default: r = tsf_pkg::REG_NONE;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Feature report one contents
  function automatic logic [31:0] feat_value();
    logic [31:0] v;
    logic [1:0] sync_code;
    v = 32'h0000_0000;
    if (!SYNC_PRESENT)
    begin
      sync_code = tsf_pkg::SUP_ABSENT;
    end
    else if (MODE_PRESENT)
    begin
      sync_code = tsf_pkg::SYNC_WITH_MODE;
    end
    else
    begin
      sync_code = tsf_pkg::SYNC_NO_MODE;
    end
    v[tsf_pkg::FEAT_SOFTWARE_OUTPUT_ENABLE_LSB +: 2] = SOFTWARE_OUTPUT_ENABLE_SUPPORT;
    v[tsf_pkg::FEAT_SYNC_ENABLE_LSB +: 2] = SYNC_ENABLE_SUPPORT;
    v[tsf_pkg::FEAT_SYNC_LSB +: 2] = sync_code;
    return v;
  endfunction

  localparam logic [31:0] FEAT_VALUE = feat_value();

  // ==========================================================
  // Bus handshake
  tsf_pkg::tsf_reg_e sel;
  logic captured_q;
  logic done;
  logic wr_sync;
  logic wr_aux;
  logic rd_cap;

  assign sel = reg_decode(PADDR);
  // One capture cycle, then ready; a frozen clock enable stalls the bus
  assign PREADY = CE && captured_q;
  assign done = PSEL && PENABLE && PREADY;
  assign PSLVERR = done && (sel == tsf_pkg::REG_NONE);
  assign wr_sync = done && PWRITE && (sel == tsf_pkg::REG_SYNC);
  assign wr_aux = done && PWRITE && (sel == tsf_pkg::REG_AUX);
  assign rd_cap = CE && PSEL && !captured_q;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      captured_q <= 1'h0;
    end
    else if (CE)
    begin
      captured_q <= PSEL && !done;
    end
  end

  // ==========================================================
  // Sync period control register
  logic sync_mode_q;
  logic [tsf_pkg::CNT_W-1:0] sync_count_q;
  logic [31:0] sync_rd;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sync_mode_q <= tsf_pkg::SYNC_MODE_RST;
      sync_count_q <= COUNT_RESET & COUNT_MASK;
    end
    else if (wr_sync && SYNC_PRESENT)
    begin
      sync_mode_q <= MODE_PRESENT && PWDATA[tsf_pkg::SYNC_MODE_BIT];
      sync_count_q <= PWDATA[tsf_pkg::CNT_W-1:0] & COUNT_MASK;
    end
  end

  always_comb
  begin
    sync_rd = 32'h0000_0000;
    if (SYNC_PRESENT)
    begin
      sync_rd[tsf_pkg::SYNC_MODE_BIT] = sync_mode_q;
      sync_rd[tsf_pkg::CNT_W-1:0] = sync_count_q;
    end
  end

  // ==========================================================
  // Auxiliary control register
  logic [31:0] aux_q;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      aux_q <= tsf_pkg::AUX_RST;
    end
    else if (wr_aux)
    begin
      aux_q <= PWDATA;
    end
  end

  assign AUX_CTRL = aux_q;

  // ==========================================================
  // Read data, captured in the cycle before ready
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (sel)
      tsf_pkg::REG_SYNC: rd_mux = sync_rd;
      tsf_pkg::REG_AUX: rd_mux = aux_q;
      tsf_pkg::REG_FEAT: rd_mux = FEAT_VALUE;
      tsf_pkg::REG_NONE: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_cap)
    begin
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
    end
  end

  assign PRDATA = prdata_q;

  // ==========================================================
  // Sync counter
  tsf_sync_if sif ();

  assign sif.load = wr_sync && SYNC_PRESENT;
  assign sif.mode = sync_mode_q;
  assign sif.count = sync_count_q;
  // All-zero contents stop the byte counter
  assign sif.active = SYNC_PRESENT && (sync_mode_q || (sync_count_q != 12'h000));
  assign sif.byte_stb = TRACE_BYTE_STB;
  assign sif.sync_en = SYNC_EN;
  assign SYNC_REQ = sif.sync_req;

  tsf_sync_counter u_counter
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .s(sif.cnt)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_mode_reset;
    $rose(RST_N) |-> !sync_mode_q && sync_count_q == (COUNT_RESET & COUNT_MASK);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("sync control not at reset value");

  property p_mode_write;
    wr_sync && SYNC_PRESENT
      |=> sync_mode_q == (MODE_PRESENT && $past(PWDATA[tsf_pkg::SYNC_MODE_BIT]));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode bit did not follow write");

  property p_count_readback;
    wr_sync && SYNC_PRESENT
      |=> sync_rd[tsf_pkg::CNT_W-1:0] == ($past(PWDATA[tsf_pkg::CNT_W-1:0]) & COUNT_MASK);
  endproperty
  a_count_readback: assert property (p_count_readback)
    else $error("count did not read back written value");

  property p_probe_read;
    rd_cap && !PWRITE && sel == tsf_pkg::REG_SYNC
      |=> PRDATA == (SYNC_PRESENT ? {19'h00000, sync_mode_q, sync_count_q} : 32'h0000_0000);
  endproperty
  a_probe_read: assert property (p_probe_read)
    else $error("sync control read data wrong");

  property p_probe_mask;
    wr_sync && SYNC_PRESENT && PWDATA[12:0] == tsf_pkg::PROBE_PATTERN
      |=> sync_count_q == COUNT_MASK && sync_mode_q == MODE_PRESENT;
  endproperty
  a_probe_mask: assert property (p_probe_mask)
    else $error("probe write left missing bits set");

  property p_aux_write;
    wr_aux |=> AUX_CTRL == $past(PWDATA) ##1 AUX_CTRL == $past(AUX_CTRL) || $past(wr_aux);
  endproperty
  a_aux_write: assert property (p_aux_write)
    else $error("auxiliary control did not hold write");

  property p_aux_reset;
    $rose(RST_N) |-> AUX_CTRL == 32'h0000_0000;
  endproperty
  a_aux_reset: assert property (p_aux_reset)
    else $error("auxiliary control not zero after reset");

  property p_feat_read;
    rd_cap && !PWRITE && sel == tsf_pkg::REG_FEAT
      |=> PRDATA[31:24] == 8'h00 && PRDATA[23:22] == SOFTWARE_OUTPUT_ENABLE_SUPPORT
          && PRDATA[21:20] == SYNC_ENABLE_SUPPORT;
  endproperty
  a_feat_read: assert property (p_feat_read)
    else $error("feature report one fields wrong");

  property p_feat_sync;
    rd_cap && !PWRITE && sel == tsf_pkg::REG_FEAT
      |=> PRDATA[9:8] == (!SYNC_PRESENT ? 2'h1 : (MODE_PRESENT ? 2'h3 : 2'h2));
  endproperty
  a_feat_sync: assert property (p_feat_sync)
    else $error("feature sync field wrong");

  property p_feat_ro;
    done && PWRITE && sel == tsf_pkg::REG_FEAT |=> $stable(aux_q) && $stable(sync_count_q);
  endproperty
  a_feat_ro: assert property (p_feat_ro)
    else $error("write to feature report changed state");

  property p_zero_stops;
    wr_sync && SYNC_PRESENT && PWDATA[12:0] == 13'h0000
      |=> !sif.active [*2];
  endproperty
  a_zero_stops: assert property (p_zero_stops)
    else $error("zero write did not stop counter");

  property p_write_sync;
    wr_sync && SYNC_PRESENT && SYNC_EN |=> SYNC_REQ;
  endproperty
  a_write_sync: assert property (p_write_sync)
    else $error("no immediate sync after write");

  property p_ready_bound;
    CE && PSEL && !PENABLE ##1 CE |-> PREADY;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("slave did not answer in one cycle");

  c_probe_write: cover property (wr_sync && PWDATA[12:0] == tsf_pkg::PROBE_PATTERN);
  c_feat_read: cover property (done && !PWRITE && sel == tsf_pkg::REG_FEAT);
  c_unmapped: cover property (PSLVERR);
  c_write_sync: cover property (wr_sync && SYNC_EN ##1 SYNC_REQ);

endmodule
`default_nettype wire

// *** verif/tsf_apb_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module tsf_apb_master
(
  // Clock
  input wire logic clk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================
  // One transfer, held until pready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready is seen high
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// *** verif/trace_sync_feature_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module trace_sync_feature_regs_tb_top;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic TRACE_BYTE_STB = 1'b0;
  logic SYNC_EN = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, sync_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, aux_ctrl, rd;
  logic er;
  int err_total = 0;
  int checks = 0;
  int n_sync = 0;
  int base;

  always #10 REF_CLK = ~REF_CLK;

  tsf_apb_master u_mst (.clk(REF_CLK), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  tsf_regs u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TRACE_BYTE_STB(TRACE_BYTE_STB), .SYNC_EN(SYNC_EN),
    .SYNC_REQ(sync_req), .AUX_CTRL(aux_ctrl));

  // Count sync requests seen
  always @(posedge REF_CLK)
    if (sync_req === 1'b1)
      n_sync <= n_sync + 1;

  // ==========================================================
  // Helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    u_mst.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(name, exp, rd);
    chk({name, " error"}, 32'h0000_0000, {31'h0, er});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_mst.xfer(1'b1, a, d, rd, er);
    // Let the write's sync pulse be counted
    repeat (2) @(posedge REF_CLK);
  endtask

  task automatic bytes_then_syncs(input int n, input int exp);
    base = n_sync;
    @(posedge REF_CLK);
    TRACE_BYTE_STB <= 1'b1;
    repeat (n) @(posedge REF_CLK);
    TRACE_BYTE_STB <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    chk("sync count", 32'(exp), 32'(n_sync - base));
  endtask

  task automatic finish_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge REF_CLK);
    err_total++;
    finish_test();
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd_chk("sync reset", tsf_pkg::OFS_SYNC, 32'h0000_0000);
    rd_chk("aux reset", tsf_pkg::OFS_AUX, 32'h0000_0000);
    rd_chk("feature", tsf_pkg::OFS_FEAT, {8'h00, tsf_pkg::SUP_PRESENT, tsf_pkg::SUP_PRESENT,
      10'h000, tsf_pkg::SYNC_WITH_MODE, 8'h00});
    wr(tsf_pkg::OFS_FEAT, 32'hFFFF_FFFF);
    rd_chk("feature ro", tsf_pkg::OFS_FEAT, 32'h00A0_0300);
    u_mst.xfer(1'b0, 12'h00C, 32'h0000_0000, rd, er);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    wr(tsf_pkg::OFS_AUX, 32'hA5C3_5A3C);
    rd_chk("aux rw", tsf_pkg::OFS_AUX, 32'hA5C3_5A3C);
    chk("aux out", 32'hA5C3_5A3C, aux_ctrl);
    wr(tsf_pkg::OFS_AUX, 32'h0000_0000);
    base = n_sync;
    wr(tsf_pkg::OFS_SYNC, 32'h0000_1FFF);
    rd_chk("probe", tsf_pkg::OFS_SYNC, 32'h0000_1FFF);
    chk("write sync", 32'h0000_0001, 32'(n_sync - base));
    base = n_sync;
    wr(tsf_pkg::OFS_SYNC, 32'h0000_0003);
    chk("write sync", 32'h0000_0001, 32'(n_sync - base));
    bytes_then_syncs(9, 3);
    bytes_then_syncs(2, 0);
    bytes_then_syncs(1, 1);
    wr(tsf_pkg::OFS_SYNC, 32'h0000_1600);
    rd_chk("pow mode", tsf_pkg::OFS_SYNC, 32'h0000_1600);
    bytes_then_syncs(4095, 0);
    bytes_then_syncs(1, 1);
    base = n_sync;
    wr(tsf_pkg::OFS_SYNC, 32'h0000_0000);
    chk("zero write sync", 32'h0000_0001, 32'(n_sync - base));
    bytes_then_syncs(40, 0);
    SYNC_EN <= 1'b0;
    base = n_sync;
    wr(tsf_pkg::OFS_SYNC, 32'h0000_0002);
    chk("gated write", 32'h0000_0000, 32'(n_sync - base));
    bytes_then_syncs(4, 0);
    // Clock enable low freezes the byte count
    SYNC_EN <= 1'b1;
    base = n_sync;
    wr(tsf_pkg::OFS_SYNC, 32'h0000_0002);
    chk("write sync", 32'h0000_0001, 32'(n_sync - base));
    CE <= 1'b0;
    bytes_then_syncs(6, 0);
    CE <= 1'b1;
    bytes_then_syncs(2, 1);
    finish_test();
  end
endmodule
`default_nettype wire
